// ===== rtl/timer16_consts.vh
// Constants for the 16-bit clear-on-match and fast PWM waveform timer
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH

// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_COUNT 8'h04
`define OFF_CMPA 8'h08
`define OFF_CMPB 8'h0C
`define OFF_CAPT 8'h10
`define OFF_FLAGS 8'h14
`define OFF_STATUS 8'h18

// Control register fields
`define CTRL_WGM 3:0
`define CTRL_COMA 5:4
`define CTRL_COMB 7:6
`define CTRL_CS 10:8
`define CTRL_DIR_A 12
`define CTRL_DIR_B 13
`define CTRL_RESET 16'h0000

// Flag register bits
`define FLG_OVF 0
`define FLG_CMPA 1
`define FLG_CMPB 2
`define FLG_CAPT 3
`define FLG_WIDTH 4

// Waveform mode codes
`define WGM_CTC_CMPA 4'h4
`define WGM_FAST_8 4'h5
`define WGM_FAST_9 4'h6
`define WGM_FAST_10 4'h7
`define WGM_CTC_CAPT 4'hC
`define WGM_FAST_CAPT 4'hE
`define WGM_FAST_CMPA 4'hF

// Output action codes
`define COM_NONE 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLR_NONINV 2'h2
`define COM_SET_INV 2'h3

// Counter limits
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF

// Prescaler select codes and divider masks
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define PSC_MASK_1 10'h000
`define PSC_MASK_8 10'h007
`define PSC_MASK_64 10'h03F
`define PSC_MASK_256 10'h0FF
`define PSC_MASK_1024 10'h3FF

`endif

// ===== rtl/timer16_ctc_fast_pwm.v
// 16-bit timer with clear-on-match and fast PWM waveform generation, Avalon-MM slave
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "timer16_consts.vh"

module timer16_ctc_fast_pwm (
	input wire clk_sys_i,
	input wire rst_b_i,
	input wire [7:0] address_i,
	input wire read_i,
	input wire write_i,
	input wire [31:0] writedata_i,
	input wire [3:0] byteenable_i,
	output wire [31:0] readdata_o,
	output wire waitrequest_o,
	output wire wave_a_o,
	output wire wave_a_oe_b_o,
	output wire wave_b_o,
	output wire wave_b_oe_b_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	function is_fast;
		input [3:0] wgm;
		begin
			is_fast = (wgm == `WGM_FAST_8) || (wgm == `WGM_FAST_9) || (wgm == `WGM_FAST_10) ||
				(wgm == `WGM_FAST_CAPT) || (wgm == `WGM_FAST_CMPA);
		end
	endfunction

	function is_ctc;
		input [3:0] wgm;
		begin
			is_ctc = (wgm == `WGM_CTC_CMPA) || (wgm == `WGM_CTC_CAPT);
		end
	endfunction

	function is_fixed_top;
		input [3:0] wgm;
		begin
			is_fixed_top = (wgm == `WGM_FAST_8) || (wgm == `WGM_FAST_9) || (wgm == `WGM_FAST_10);
		end
	endfunction

	// Outside the two supported modes the counter simply runs to maximum
	function [15:0] top_of;
		input [3:0] wgm;
		input [15:0] cmpa;
		input [15:0] capt;
		begin
			case (wgm)
				`WGM_FAST_8: top_of = `TOP_8BIT;
				`WGM_FAST_9: top_of = `TOP_9BIT;
				`WGM_FAST_10: top_of = `TOP_10BIT;
				`WGM_CTC_CMPA, `WGM_FAST_CMPA: top_of = cmpa;
				`WGM_CTC_CAPT, `WGM_FAST_CAPT: top_of = capt;
				default: top_of = `CNT_MAX;
			endcase
		end
	endfunction

	function [9:0] psc_mask;
		input [2:0] cs;
		begin
			case (cs)
				`CS_DIV8: psc_mask = `PSC_MASK_8;
				`CS_DIV64: psc_mask = `PSC_MASK_64;
				`CS_DIV256: psc_mask = `PSC_MASK_256;
				`CS_DIV1024: psc_mask = `PSC_MASK_1024;
				default: psc_mask = `PSC_MASK_1;
			endcase
		end
	endfunction

	function [15:0] merge_be;
		input [15:0] old;
		input [31:0] data;
		input [3:0] be;
		begin
			merge_be = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reset release

	reg rst_meta_reg;
	reg rst_sync_reg;

	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State and decode

	reg [15:0] ctrl_reg;
	reg [15:0] cnt_reg;
	reg [15:0] cnt_next;
	reg [31:0] cmp_buf_reg;
	reg [31:0] cmp_act_reg;
	reg [15:0] capt_reg;
	reg [`FLG_WIDTH-1:0] flags_reg;
	reg [`FLG_WIDTH-1:0] flags_set;
	reg [9:0] psc_reg;
	reg waitrequest_reg;
	reg [31:0] readdata_reg;
	reg [31:0] rd_mux;
	reg wave_a_reg;
	reg wave_a_oe_b_reg;
	reg wave_b_reg;
	reg wave_b_oe_b_reg;

	wire acc_go = (read_i | write_i) & waitrequest_reg;
	wire wr_go = write_i & acc_go;
	wire wr_ctrl = wr_go && (address_i == `OFF_CTRL);
	wire wr_count = wr_go && (address_i == `OFF_COUNT);
	wire wr_cmpa = wr_go && (address_i == `OFF_CMPA);
	wire wr_cmpb = wr_go && (address_i == `OFF_CMPB);
	wire wr_capt = wr_go && (address_i == `OFF_CAPT);
	wire wr_flags = wr_go && (address_i == `OFF_FLAGS);

	wire [3:0] wgm = ctrl_reg[`CTRL_WGM];
	wire fast = is_fast(wgm);
	wire ctc = is_ctc(wgm);
	wire [2:0] cs = ctrl_reg[`CTRL_CS];

	// Only fast PWM reads the active copy; other modes read the buffer and see writes at once
	wire [31:0] cmp_eff = fast ? cmp_act_reg : cmp_buf_reg;
	wire [15:0] top = top_of(wgm, cmp_eff[15:0], capt_reg);
	wire at_top = (cnt_reg == top);
	wire at_max = (cnt_reg == `CNT_MAX);

	// A stopped prescaler leaves the counter frozen
	wire tick = (cs != `CS_STOP) && ((psc_reg & psc_mask(cs)) == psc_mask(cs));

	// Bits above a fixed top are dropped on write
	wire [15:0] wmask = is_fixed_top(wgm) ? top : `CNT_MAX;
	wire [15:0] cmpa_wdata = merge_be(cmp_buf_reg[15:0], writedata_i, byteenable_i) & wmask;
	wire [15:0] cmpb_wdata = merge_be(cmp_buf_reg[31:16], writedata_i, byteenable_i) & wmask;

	wire [1:0] oc_vec;
	wire [1:0] match;

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler and counter

	always @(posedge clk_sys_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			psc_reg <= 10'h000;
		end else if (cs == `CS_STOP) begin
			psc_reg <= 10'h000;
		end else begin
			psc_reg <= psc_reg + 10'h001;
		end
	end

	always @* begin
		cnt_next = cnt_reg;
		if (wr_count) begin
			cnt_next = merge_be(cnt_reg, writedata_i, byteenable_i);
		end else if (tick) begin
			if ((fast || ctc) && at_top) begin
				cnt_next = `CNT_BOTTOM;
			end else begin
				cnt_next = cnt_reg + 16'h0001;
			end
		end
	end

	always @(posedge clk_sys_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			cnt_reg <= `CNT_BOTTOM;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare, capture and control registers

	always @(posedge clk_sys_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			ctrl_reg <= `CTRL_RESET;
			cmp_buf_reg <= {`CNT_BOTTOM, `CNT_BOTTOM};
			cmp_act_reg <= {`CNT_BOTTOM, `CNT_BOTTOM};
			capt_reg <= `CNT_BOTTOM;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= merge_be(ctrl_reg, writedata_i, byteenable_i);
			end
			if (wr_cmpa) begin
				cmp_buf_reg[15:0] <= cmpa_wdata;
			end
			if (wr_cmpb) begin
				cmp_buf_reg[31:16] <= cmpb_wdata;
			end
			if (wr_capt) begin
				capt_reg <= merge_be(capt_reg, writedata_i, byteenable_i);
			end
			// Keeping the active copy in step outside fast PWM makes a mode switch clean
			if (!fast || (tick && at_top)) begin
				cmp_act_reg <= cmp_buf_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags: a set in the same cycle as a clear wins

	always @* begin
		flags_set = {`FLG_WIDTH{1'b0}};
		flags_set[`FLG_OVF] = tick && (fast ? at_top : at_max);
		flags_set[`FLG_CMPA] = match[0];
		flags_set[`FLG_CMPB] = match[1];
		flags_set[`FLG_CAPT] = tick && at_top &&
			((wgm == `WGM_CTC_CAPT) || (wgm == `WGM_FAST_CAPT));
	end

	always @(posedge clk_sys_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			flags_reg <= {`FLG_WIDTH{1'b0}};
		end else if (wr_flags && byteenable_i[0]) begin
			flags_reg <= (flags_reg & ~writedata_i[`FLG_WIDTH-1:0]) | flags_set;
		end else begin
			flags_reg <= flags_reg | flags_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Waveform output per channel

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chan
			reg oc_reg;
			reg oc_next;
			wire [1:0] com = (ch == 0) ? ctrl_reg[`CTRL_COMA] : ctrl_reg[`CTRL_COMB];
			wire toggle_ok = (ch == 0) && (!fast || (wgm == `WGM_FAST_CMPA));

			// Compare above top never equals the counter before it clears
			assign match[ch] = tick && (cnt_reg == cmp_eff[ch*16 +: 16]);
			assign oc_vec[ch] = oc_reg;

			// Action is read live, so a new setting acts at the next top or match
			always @* begin
				oc_next = oc_reg;
				if (fast && tick && at_top) begin
					if (com == `COM_CLR_NONINV) begin
						oc_next = 1'b0;
					end else if (com == `COM_SET_INV) begin
						oc_next = 1'b1;
					end
				end
				// Match after the top action, so compare equal to top holds a constant level for the clear and set actions
				if (match[ch]) begin
					case (com)
						`COM_TOGGLE: begin
							if (toggle_ok) begin
								oc_next = ~oc_reg;
							end
						end
						`COM_CLR_NONINV: begin
							oc_next = fast;
						end
						`COM_SET_INV: begin
							oc_next = !fast;
						end
						default: begin
							oc_next = oc_reg;
						end
					endcase
				end
			end

			always @(posedge clk_sys_i or negedge rst_sync_reg) begin
				if (!rst_sync_reg) begin
					oc_reg <= 1'b0;
				end else begin
					oc_reg <= oc_next;
				end
			end
		end
	endgenerate

	// Pins are enabled only when their direction bit selects output
	always @(posedge clk_sys_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			wave_a_reg <= 1'b0;
			wave_a_oe_b_reg <= 1'b1;
			wave_b_reg <= 1'b0;
			wave_b_oe_b_reg <= 1'b1;
		end else begin
			wave_a_reg <= oc_vec[0];
			wave_a_oe_b_reg <= ~ctrl_reg[`CTRL_DIR_A];
			wave_b_reg <= oc_vec[1];
			wave_b_oe_b_reg <= ~ctrl_reg[`CTRL_DIR_B];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait state, then one cycle with waitrequest low

	always @* begin
		case (address_i)
			`OFF_CTRL: rd_mux = {16'h0000, ctrl_reg};
			`OFF_COUNT: rd_mux = {16'h0000, cnt_reg};
			`OFF_CMPA: rd_mux = {16'h0000, cmp_buf_reg[15:0]};
			`OFF_CMPB: rd_mux = {16'h0000, cmp_buf_reg[31:16]};
			`OFF_CAPT: rd_mux = {16'h0000, capt_reg};
			`OFF_FLAGS: rd_mux = {28'h0000000, flags_reg};
			`OFF_STATUS: rd_mux = {cmp_act_reg[15:0], 14'h0000, oc_vec};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge clk_sys_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			waitrequest_reg <= 1'b1;
			readdata_reg <= 32'h00000000;
		end else if (acc_go) begin
			waitrequest_reg <= 1'b0;
			if (read_i) begin
				readdata_reg <= rd_mux;
			end
		end else begin
			waitrequest_reg <= 1'b1;
		end
	end

	assign readdata_o = readdata_reg;
	assign waitrequest_o = waitrequest_reg;
	assign wave_a_o = wave_a_reg;
	assign wave_a_oe_b_o = wave_a_oe_b_reg;
	assign wave_b_o = wave_b_reg;
	assign wave_b_oe_b_o = wave_b_oe_b_reg;

endmodule

// ===== tb/pin_load.sv
// External load on a waveform pin: resolves the line and measures high time and period
`timescale 1ns/10ps
module pin_load (
	input wire clk_i,
	input wire wave_i,
	input wire oe_b_i,
	output wire pin_o,
	output int hi_o,
	output int per_o
);
	int cyc = 0;
	int rise_at = 0;
	logic last = 1'b0;
	// Pull-down holds a released line low, so a stale level cannot pass
	assign pin_o = oe_b_i ? 1'b0 : wave_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		last <= pin_o;
		if (pin_o && !last) begin
			per_o <= cyc - rise_at;
			rise_at <= cyc;
		end
		if (!pin_o && last)
			hi_o <= cyc - rise_at;
	end
endmodule

// ===== tb/timer16_ctc_fast_pwm_monitor.sv
// Checker for bus handshake, pin enables and waveform timing
`timescale 1ns/10ps
`include "timer16_consts.vh"
module timer16_ctc_fast_pwm_monitor (
	input wire clk_sys_i,
	input wire rst_b_i,
	input wire [7:0] address_i,
	input wire read_i,
	input wire write_i,
	input wire [31:0] writedata_i,
	input wire [3:0] byteenable_i,
	input wire [31:0] readdata_o,
	input wire waitrequest_o,
	input wire wave_a_o,
	input wire wave_a_oe_b_o,
	input wire wave_b_o,
	input wire wave_b_oe_b_o
);
	logic [15:0] ctrl_reg, cmpa_reg, run_reg;
	logic [3:0] since_reg;
	logic edge_reg;
	wire take = write_i && waitrequest_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////////////////////////////////////////////
	// Toggle run length only counts once a change was seen after the last write
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_reg <= 16'h0000;
			cmpa_reg <= 16'h0000;
			run_reg <= 16'h0000;
			since_reg <= 4'h0;
			edge_reg <= 1'b0;
		end else begin
			if (take && address_i == `OFF_CTRL)
				ctrl_reg <= writedata_i[15:0];
			if (take && address_i == `OFF_CMPA)
				cmpa_reg <= writedata_i[15:0];
			since_reg <= take ? 4'h0 : since_reg + {3'h0, since_reg != 4'hF};
			run_reg <= $changed(wave_a_o) ? 16'h0001 : run_reg + 16'h0001;
			if (take)
				edge_reg <= 1'b0;
			else if ($changed(wave_a_o))
				edge_reg <= 1'b1;
		end
	end
	sequence ctrl_write;
		take && address_i == `OFF_CTRL;
	endsequence
	sequence rd_unmapped;
		read_i && waitrequest_o && address_i > `OFF_STATUS;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_wait_one: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("ack not one cycle after request");
	a_ack_single: assert property (!waitrequest_o |=> waitrequest_o)
		else $error("ack longer than one cycle");
	a_no_idle_ack: assert property (!(read_i || write_i) |=> waitrequest_o)
		else $error("ack without request");
	a_unmapped_zero: assert property (rd_unmapped |=> readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_pin_enable: assert property (
		ctrl_write |=> ##1 {wave_b_oe_b_o, wave_a_oe_b_o} == ~$past(writedata_i[13:12], 2))
		else $error("pin enable not from direction bits");
	a_action_none: assert property (
		since_reg >= 4'h4 |-> (ctrl_reg[5:4] != `COM_NONE || $stable(wave_a_o))
		&& (ctrl_reg[7:6] != `COM_NONE || $stable(wave_b_o)))
		else $error("output moved with no action");
	a_stopped_frozen: assert property (
		ctrl_reg[10:8] == `CS_STOP && since_reg >= 4'h4 |-> $stable(wave_a_o) && $stable(wave_b_o))
		else $error("output moved while stopped");
	a_toggle_period: assert property (
		ctrl_reg[3:0] == `WGM_CTC_CMPA && ctrl_reg[5:4] == `COM_TOGGLE
		&& ctrl_reg[10:8] == `CS_DIV1 && edge_reg && $changed(wave_a_o)
		|-> run_reg == cmpa_reg + 16'h0001)
		else $error("toggle half period wrong");
endmodule
bind timer16_ctc_fast_pwm timer16_ctc_fast_pwm_monitor mon (.clk_sys_i(clk_sys_i),
	.rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
	.writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
	.waitrequest_o(waitrequest_o), .wave_a_o(wave_a_o), .wave_a_oe_b_o(wave_a_oe_b_o),
	.wave_b_o(wave_b_o), .wave_b_oe_b_o(wave_b_oe_b_o));

// ===== tb/tb_timer16_ctc_fast_pwm.sv
// Self-checking bench for the clear-on-match and fast PWM timer
`timescale 1ns/10ps
`include "timer16_consts.vh"
module tb_timer16_ctc_fast_pwm;
	logic clk_sys_i = 1'b0, rst_b_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
	logic [7:0] address_i = 8'h00;
	logic [31:0] writedata_i = 32'h0, q;
	logic [3:0] byteenable_i = 4'hF;
	wire [31:0] readdata_o;
	wire waitrequest_o, wave_a_o, wave_a_oe_b_o, wave_b_o, wave_b_oe_b_o, pin_a;
	int fails = 0, n_checks = 0, cyc = 0, hi_a, per_a, c, i;
	int nd[6] = '{0, 1, 8, 64, 256, 1024};
	timer16_ctc_fast_pwm DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
		.byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.wave_a_o(wave_a_o), .wave_a_oe_b_o(wave_a_oe_b_o), .wave_b_o(wave_b_o),
		.wave_b_oe_b_o(wave_b_oe_b_o));
	pin_load load_a (.clk_i(clk_sys_i), .wave_i(wave_a_o), .oe_b_i(wave_a_oe_b_o),
		.pin_o(pin_a), .hi_o(hi_a), .per_o(per_a));
	initial forever #2.5 clk_sys_i = ~clk_sys_i;
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Request held until ack is sampled, then released after that edge
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		read_i <= !wr;
		write_i <= wr;
		address_i <= a;
		writedata_i <= d;
		@(posedge clk_sys_i);
		while (waitrequest_o !== 1'b0)
			@(posedge clk_sys_i);
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	function automatic logic [31:0] ctl(input int m, input int a, input int s, input logic d);
		return {18'h0, d, d, 1'b0, s[2:0], 2'h0, a[1:0], m[3:0]};
	endfunction
	// Model: period and high time of pin A from mode, action, prescale and registers
	task automatic wave(input int m, input int a, input int s, input int cv, input int tp);
		int top, n, per, hi;
		n = nd[s];
		top = m == 5 ? 255 : m == 6 ? 511 : m == 7 ? 1023 : m == 14 ? tp : cv;
		per = a == 1 ? 2 * n * (1 + cv) : n * (top + 1);
		hi = a == 1 ? per / 2 : a == 2 ? n * (top - cv) : n * (cv + 1);
		acc(1, `OFF_CTRL, ctl(m, a, 0, 1));
		acc(1, `OFF_COUNT, 0);
		acc(1, `OFF_CAPT, tp);
		acc(1, `OFF_CMPA, cv);
		acc(1, `OFF_FLAGS, 32'hF);
		acc(1, `OFF_CTRL, ctl(m, a, s, 1));
		repeat (3 * per + 10) @(posedge clk_sys_i);
		chk("period", per, per_a);
		chk("high time", hi, hi_a);
		chk("pin B enable", 0, wave_b_oe_b_o);
		chk("channel B level", 0, wave_b_o);
		acc(0, `OFF_FLAGS, 0);
		chk("flags", {m == 14, 2'b01, m != 4}, q & 32'hB);
		acc(0, `OFF_STATUS, 0);
		chk("active compare", cv, q[31:16]);
		$display("wave test mode %0d action %0d done", m, a);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		void'($urandom(32'h9616c387));
		for (i = 0; i < 8; i++) begin
			acc(0, i * 4, 0);
			chk("reset value", 0, q);
		end
		chk("pin enable", 1, wave_a_oe_b_o);
		chk("pin B enable", 1, wave_b_oe_b_o);
		$display("reset test done");
		acc(1, `OFF_CTRL, ctl(5, 2, 0, 1));
		acc(1, `OFF_CMPA, 32'h0000ABCD);
		acc(0, `OFF_CMPA, 0);
		chk("masked compare", 32'h00CD, q);
		acc(0, `OFF_STATUS, 0);
		chk("unloaded compare", 0, q[31:16]);
		$display("buffer test done");
		c = $urandom_range(200, 3);
		wave(5, 2, 1, c, 0);
		wave(6, 3, 1, $urandom_range(400, 3), 0);
		wave(7, 2, 1, $urandom_range(900, 3), 0);
		wave(5, 3, 1, 0, 0);
		wave(14, 3, 1, c, c + $urandom_range(300, 3));
		wave(15, 1, 1, $urandom_range(200, 3), 0);
		wave(4, 1, 1, $urandom_range(200, 0), 0);
		wave(4, 1, 2, $urandom_range(200, 0), 0);
		acc(1, `OFF_CTRL, ctl(15, 1, 1, 0));
		repeat (40) begin
			@(posedge clk_sys_i);
			chk("released pin", 0, pin_a);
		end
		$display("direction test done");
		acc(1, `OFF_CTRL, ctl(4, 0, 0, 1));
		acc(1, `OFF_COUNT, 32'hFFF8);
		acc(1, `OFF_CMPA, 5);
		acc(1, `OFF_FLAGS, 32'hF);
		acc(1, `OFF_CTRL, ctl(4, 0, 1, 1));
		acc(0, `OFF_FLAGS, 0);
		chk("flags before wrap", 0, q & 32'h3);
		repeat (30) @(posedge clk_sys_i);
		acc(0, `OFF_FLAGS, 0);
		chk("flags after wrap", 3, q & 32'h3);
		$display("wrap test done");
		tally_and_finish();
	end
endmodule
